// ---- design/lapo_pkg.sv ----
// Constants, state codes and carrier types for the access point open command block.
// Assumes an APB master for software and a 16-bit word read port to system memory.
//
// Overview of operation
// - Block address: low byte of word a, word b
// - Response timer 1..10, zero gives 5; values above 10 are stored, not refused
// - Ack timer zero gives 2, above 10 off
// - Ack sent soon after ack timer expiry
// - Inactivity timer zero gives 3, tests link
// - Transmit window zero gives 2, max 127
// - Receive window zero gives 1, max 127
// - Window step zero gives 1
// - Retransmit limit zero gives 8, max 255
// - Group capacity used only with bit 6
// - Priority from bits 0-2, above 6 rejected
// - Bit 4 forwards identification commands to host
// - Bits 5-7 legal combination else 0006
// - Field length zero gives 600, station-dependent
// - Station count needs bit 5, zero type 1
// - Membership count valid with bits 5, 7
// - Completion: event, 0015, status, identifier
// - Group failures return offending group value
// - 0045 missing group, 0049 group full
// - 0000, 0042, 0043, 0046 status codes
// - Reject unless opened and interface enabled
package lapo_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CMD_A = 8'h00;
    localparam logic [7:0] OFF_CMD_B = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_STAT_CMD = 8'h0c;
    localparam logic [7:0] OFF_STAT_A = 8'h10;
    localparam logic [7:0] OFF_STAT_B = 8'h14;
    localparam logic [7:0] OFF_STAT_C = 8'h18;
    localparam logic [7:0] OFF_FLAGS = 8'h1c;
    localparam logic [7:0] OFF_LIMIT = 8'h20;
    localparam logic [7:0] OFF_TIMERS = 8'h24;
    localparam logic [7:0] OFF_WINDOWS = 8'h28;
    localparam logic [7:0] OFF_POINT = 8'h2c;
    // Control and flag bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_OPEN = 1;
    localparam int CTRL_LLC = 2;
    localparam int FLAG_BUSY = 0;
    localparam int FLAG_DONE = 1;
    localparam int FLAG_REJECT = 2;
    // Option bit positions
    localparam int OPT_XID = 4;
    localparam int OPT_IND = 5;
    localparam int OPT_GRP = 6;
    localparam int OPT_MBR = 7;
    // Status codes and completion command word
    localparam logic [15:0] CMD_CODE = 16'h0015;
    localparam logic [15:0] ST_OK = 16'h0000;
    localparam logic [15:0] ST_OPTIONS = 16'h0006;
    localparam logic [15:0] ST_PRIORITY = 16'h0008;
    localparam logic [15:0] ST_PARAM_MAX = 16'h0042;
    localparam logic [15:0] ST_BAD_VALUE = 16'h0043;
    localparam logic [15:0] ST_NO_GROUP = 16'h0045;
    localparam logic [15:0] ST_NO_ROOM = 16'h0046;
    localparam logic [15:0] ST_GROUP_FULL = 16'h0049;
    // Defaults and limits
    localparam logic [7:0] DEF_T1 = 8'h05;
    localparam logic [7:0] DEF_T2 = 8'h02;
    localparam logic [7:0] DEF_TI = 8'h03;
    localparam logic [7:0] TIMER_MAX = 8'h0a;
    localparam logic [7:0] TIMER_GROUP1_MAX = 8'h05;
    localparam logic [7:0] DEF_TX_WIN = 8'h02;
    localparam logic [7:0] DEF_RX_WIN = 8'h01;
    localparam logic [7:0] DEF_STEP = 8'h01;
    localparam logic [7:0] DEF_RETRY = 8'h08;
    localparam logic [7:0] WIN_MAX = 8'h7f;
    localparam logic [15:0] DEF_FIELD = 16'h0258;
    localparam logic [2:0] PRIO_MAX = 3'h6;
    localparam logic [7:0] LIST_MAX = 8'h08;
    localparam logic [3:0] FIRST_WORD = 4'h2;
    localparam logic [3:0] LAST_WORD = 4'hb;
    localparam logic [7:0] LIMIT_RESET = 8'h00;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_FETCH = 5'b00010,
        S_LIST = 5'b00100,
        S_CHECK = 5'b01000,
        S_DONE = 5'b10000
    } lapo_state_t;

    // Settings of the last access point opened successfully
    typedef struct packed {
        logic [7:0] value;
        logic [2:0] priority_level;
        logic host_answers_identification;
        logic individual_point_flag;
        logic group_point_flag;
        logic member_flag;
        logic [7:0] response_timer_setting;
        logic response_timer_group2;
        logic [7:0] receive_ack_timer_setting;
        logic receive_ack_timer_group2;
        logic receive_ack_timer_enabled;
        logic [7:0] inactivity_timer_setting;
        logic inactivity_timer_group2;
        logic [7:0] transmit_window_limit;
        logic [7:0] receive_window_limit;
        logic [7:0] window_increment_step;
        logic [7:0] retransmit_limit_value;
        logic [7:0] group_capacity;
        logic [15:0] max_field_length;
        logic [7:0] station_count;
    } lapo_cfg_t;

    // Word read request to system memory
    typedef struct packed {
        logic req;
        logic [23:0] addr;
    } lapo_mem_req_t;
endpackage : lapo_pkg

// ---- design/lapo_open_point.sv ----
// Access point open command interpreter: fetches the setup block, applies defaults,
// checks limits and group membership, stores the access point and reports status.
// Assumes system memory answers mem_ack on pclk with one 16-bit word per request.
`timescale 1ns/1ps
`default_nettype none
module lapo_open_point
    import lapo_pkg::*;
#(
    parameter int AP_CAP = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System memory read port
    output lapo_mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    // Completion events and stored settings
    output logic status_event,
    output logic reject_event,
    output lapo_cfg_t cfg_out
);
    // ==========================================================
    // State
    typedef struct packed {
        lapo_state_t st;
        logic [15:0] cmd_a;
        logic [15:0] cmd_b;
        logic open_flag;
        logic llc_flag;
        logic [7:0] group_limit;
        logic [15:0] stat_cmd;
        logic [15:0] stat_a;
        logic [15:0] stat_b;
        logic [15:0] stat_c;
        logic done_flag;
        logic reject_flag;
        logic status_event;
        logic reject_event;
        logic [3:0] widx;
        lapo_mem_req_t mem;
        logic [LAST_WORD:0][15:0] blk;
        logic [7:0][7:0] glist;
        lapo_cfg_t cfg;
        logic [AP_CAP-1:0] e_valid;
        logic [AP_CAP-1:0] e_group;
        logic [AP_CAP-1:0][7:0] e_value;
        logic [AP_CAP-1:0][7:0] e_cap;
        logic [AP_CAP-1:0][7:0] e_mem;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } st_t;

    st_t r_reg;
    st_t r_next;

    // ==========================================================
    // Field decode of the fetched block (first field in high byte)
    logic [7:0] raw_t1, raw_t2, raw_ti, raw_tx, raw_rx, raw_step, raw_retry, raw_gcap;
    logic [7:0] raw_value, raw_opts, raw_stations, raw_gm;
    logic [15:0] raw_field;
    logic [23:0] list_ptr;
    logic [23:0] blk_ptr;
    assign raw_t1 = r_reg.blk[2][15:8];
    assign raw_t2 = r_reg.blk[2][7:0];
    assign raw_ti = r_reg.blk[3][15:8];
    assign raw_tx = r_reg.blk[3][7:0];
    assign raw_rx = r_reg.blk[4][15:8];
    assign raw_step = r_reg.blk[4][7:0];
    assign raw_retry = r_reg.blk[5][15:8];
    assign raw_gcap = r_reg.blk[5][7:0];
    assign raw_field = r_reg.blk[6];
    assign raw_value = r_reg.blk[7][15:8];
    assign raw_opts = r_reg.blk[7][7:0];
    assign raw_stations = r_reg.blk[8][15:8];
    assign raw_gm = r_reg.blk[9][7:0];
    assign list_ptr = {r_reg.blk[10][7:0], r_reg.blk[11]};
    assign blk_ptr = {r_reg.cmd_a[7:0], r_reg.cmd_b};

    logic opt_ind, opt_grp, opt_mbr;
    logic [7:0] eff_gm;
    assign opt_ind = raw_opts[OPT_IND];
    assign opt_grp = raw_opts[OPT_GRP];
    assign opt_mbr = raw_opts[OPT_MBR];
    assign eff_gm = (opt_ind && opt_mbr) ? raw_gm : 8'h00;

    // ==========================================================
    // Checks and the settings that a success would store
    lapo_cfg_t cand;
    logic [15:0] verdict;
    logic [7:0] failing;
    logic [AP_CAP-1:0] grp_hit;
    always_comb begin
        logic found;
        logic full;
        logic in_use;
        logic have_slot;
        found = 1'b0;
        full = 1'b0;
        in_use = 1'b0;
        have_slot = 1'b0;
        failing = 8'h00;
        grp_hit = '0;
        cand = '0;
        cand.value = raw_value;
        cand.priority_level = raw_opts[2:0];
        cand.host_answers_identification = raw_opts[OPT_XID];
        cand.individual_point_flag = opt_ind;
        cand.group_point_flag = opt_grp;
        cand.member_flag = opt_mbr;
        cand.response_timer_setting = (raw_t1 == 8'h00) ? DEF_T1 : raw_t1;
        cand.response_timer_group2 = cand.response_timer_setting > TIMER_GROUP1_MAX;
        cand.receive_ack_timer_setting = (raw_t2 == 8'h00) ? DEF_T2 : raw_t2;
        cand.receive_ack_timer_group2 = cand.receive_ack_timer_setting > TIMER_GROUP1_MAX;
        cand.receive_ack_timer_enabled = cand.receive_ack_timer_setting <= TIMER_MAX;
        cand.inactivity_timer_setting = (raw_ti == 8'h00) ? DEF_TI : raw_ti;
        cand.inactivity_timer_group2 = cand.inactivity_timer_setting > TIMER_GROUP1_MAX;
        cand.transmit_window_limit = (raw_tx == 8'h00) ? DEF_TX_WIN : raw_tx;
        cand.receive_window_limit = (raw_rx == 8'h00) ? DEF_RX_WIN : raw_rx;
        cand.window_increment_step = (raw_step == 8'h00) ? DEF_STEP : raw_step;
        cand.retransmit_limit_value = (raw_retry == 8'h00) ? DEF_RETRY : raw_retry;
        cand.group_capacity = opt_grp ? raw_gcap : 8'h00;
        cand.station_count = opt_ind ? raw_stations : 8'h00;
        // Field length only matters once stations may exist
        if (cand.station_count == 8'h00) begin
            cand.max_field_length = 16'h0000;
        end else begin
            cand.max_field_length = (raw_field == 16'h0000) ? DEF_FIELD : raw_field;
        end
        for (int j = 0; j < AP_CAP; j++) begin
            if (r_reg.e_valid[j] && r_reg.e_value[j] == raw_value) begin
                in_use = 1'b1;
            end
            if (!r_reg.e_valid[j]) begin
                have_slot = 1'b1;
            end
        end
        // First offending list entry in list order wins
        for (int i = 7; i >= 0; i--) begin
            logic hit;
            logic room;
            hit = 1'b0;
            room = 1'b0;
            if (8'(i) < eff_gm) begin
                for (int j = 0; j < AP_CAP; j++) begin
                    if (r_reg.e_valid[j] && r_reg.e_group[j] &&
                        r_reg.e_value[j] == r_reg.glist[i]) begin
                        hit = 1'b1;
                        room = r_reg.e_mem[j] < r_reg.e_cap[j];
                        grp_hit[j] = 1'b1;
                    end
                end
                if (!hit || !room) begin
                    found = !hit;
                    full = hit;
                    failing = r_reg.glist[i];
                end
            end
        end
        if (!(opt_ind || opt_grp || opt_mbr) || (opt_mbr && !opt_ind)) begin
            verdict = ST_OPTIONS;
        end else if (raw_opts[2:0] > PRIO_MAX) begin
            verdict = ST_PRIORITY;
        end else if (raw_tx > WIN_MAX || raw_rx > WIN_MAX || eff_gm > LIST_MAX ||
                     cand.group_capacity > r_reg.group_limit) begin
            verdict = ST_PARAM_MAX;
        end else if (raw_value == 8'h00 || raw_value[0] || in_use) begin
            verdict = ST_BAD_VALUE;
        end else if (!have_slot) begin
            verdict = ST_NO_ROOM;
        end else if (found) begin
            verdict = ST_NO_GROUP;
        end else if (full) begin
            verdict = ST_GROUP_FULL;
        end else begin
            verdict = ST_OK;
        end
    end

    // ==========================================================
    // Register read mux
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (paddr)
            OFF_CMD_A: rd_word = {16'h0000, r_reg.cmd_a};
            OFF_CMD_B: rd_word = {16'h0000, r_reg.cmd_b};
            OFF_CTRL: rd_word = {29'h0, r_reg.llc_flag, r_reg.open_flag, 1'b0};
            OFF_STAT_CMD: rd_word = {16'h0000, r_reg.stat_cmd};
            OFF_STAT_A: rd_word = {16'h0000, r_reg.stat_a};
            OFF_STAT_B: rd_word = {16'h0000, r_reg.stat_b};
            OFF_STAT_C: rd_word = {16'h0000, r_reg.stat_c};
            OFF_FLAGS: rd_word = {29'h0, r_reg.reject_flag, r_reg.done_flag,
                                  r_reg.st != S_IDLE};
            OFF_LIMIT: rd_word = {24'h000000, r_reg.group_limit};
            OFF_TIMERS: rd_word = {8'h00, r_reg.cfg.inactivity_timer_setting,
                                   r_reg.cfg.receive_ack_timer_setting,
                                   r_reg.cfg.response_timer_setting};
            OFF_WINDOWS: rd_word = {r_reg.cfg.retransmit_limit_value,
                                    r_reg.cfg.window_increment_step,
                                    r_reg.cfg.receive_window_limit,
                                    r_reg.cfg.transmit_window_limit};
            OFF_POINT: rd_word = {r_reg.cfg.max_field_length, r_reg.cfg.station_count,
                                  r_reg.cfg.value};
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    logic bus_done;
    logic wr_ctrl;
    assign bus_done = psel && penable && r_reg.pready;
    assign wr_ctrl = bus_done && pwrite && paddr == OFF_CTRL;

    always_comb begin
        int slot;
        slot = 0;
        r_next = r_reg;
        r_next.status_event = 1'b0;
        r_next.reject_event = 1'b0;
        // One wait state so read data comes from a flip-flop
        r_next.pready = psel && penable && !r_reg.pready;
        r_next.pslverr = psel && penable && !r_reg.pready && !rd_hit;
        if (psel && penable && !r_reg.pready) begin
            r_next.prdata = rd_word;
        end
        if (bus_done && pwrite) begin
            unique case (paddr)
                OFF_CMD_A: r_next.cmd_a = pwdata[15:0];
                OFF_CMD_B: r_next.cmd_b = pwdata[15:0];
                OFF_CTRL: begin
                    r_next.open_flag = pwdata[CTRL_OPEN];
                    r_next.llc_flag = pwdata[CTRL_LLC];
                end
                OFF_FLAGS: begin
                    // Write one clears; a same-cycle event below still sets
                    if (pwdata[FLAG_DONE]) r_next.done_flag = 1'b0;
                    if (pwdata[FLAG_REJECT]) r_next.reject_flag = 1'b0;
                end
                OFF_LIMIT: r_next.group_limit = pwdata[7:0];
                default: begin
                end
            endcase
        end
        unique case (r_reg.st)
            S_IDLE: begin
                if (wr_ctrl && pwdata[CTRL_START]) begin
                    if (!(r_reg.open_flag && r_reg.llc_flag)) begin
                        r_next.reject_event = 1'b1;
                        r_next.reject_flag = 1'b1;
                    end else begin
                        r_next.st = S_FETCH;
                        r_next.widx = FIRST_WORD;
                        r_next.mem.req = 1'b1;
                        r_next.mem.addr = blk_ptr + 24'({FIRST_WORD, 1'b0});
                    end
                end
            end
            S_FETCH: begin
                if (r_reg.mem.req && mem_ack) begin
                    r_next.blk[r_reg.widx] = mem_rdata;
                    r_next.mem.req = 1'b0;
                    if (r_reg.widx == LAST_WORD) begin
                        r_next.widx = 4'h0;
                        // An oversized count skips the list; the check refuses it
                        r_next.st = (eff_gm != 8'h00 && eff_gm <= LIST_MAX) ? S_LIST : S_CHECK;
                    end else begin
                        r_next.widx = r_reg.widx + 4'h1;
                    end
                end else if (!r_reg.mem.req) begin
                    r_next.mem.req = 1'b1;
                    r_next.mem.addr = blk_ptr + 24'({r_reg.widx, 1'b0});
                end
            end
            S_LIST: begin
                if (r_reg.mem.req && mem_ack) begin
                    r_next.glist[{r_reg.widx[1:0], 1'b0}] = mem_rdata[15:8];
                    r_next.glist[{r_reg.widx[1:0], 1'b1}] = mem_rdata[7:0];
                    r_next.mem.req = 1'b0;
                    r_next.widx = r_reg.widx + 4'h1;
                    if ({r_reg.widx[2:0], 1'b1} >= eff_gm[3:0] - 4'h1) begin
                        r_next.st = S_CHECK;
                    end
                end else if (!r_reg.mem.req) begin
                    r_next.mem.req = 1'b1;
                    r_next.mem.addr = list_ptr + 24'({r_reg.widx, 1'b0});
                end
            end
            S_CHECK: begin
                r_next.st = S_DONE;
                r_next.stat_cmd = CMD_CODE;
                r_next.stat_a = verdict;
                r_next.stat_b = 16'h0000;
                r_next.stat_c = 16'h0000;
                if (verdict == ST_NO_GROUP || verdict == ST_GROUP_FULL) begin
                    r_next.stat_c = {8'h00, failing};
                end
                if (verdict == ST_OK) begin
                    r_next.stat_b = {raw_value, 8'h00};
                    r_next.cfg = cand;
                    for (int j = 0; j < AP_CAP; j++) begin
                        if (grp_hit[j]) begin
                            r_next.e_mem[j] = r_reg.e_mem[j] + 8'h01;
                        end
                    end
                    // Lowest free slot takes the new access point
                    for (int j = AP_CAP - 1; j >= 0; j--) begin
                        if (!r_reg.e_valid[j]) begin
                            slot = j;
                        end
                    end
                    r_next.e_valid[slot] = 1'b1;
                    r_next.e_group[slot] = opt_grp;
                    r_next.e_value[slot] = raw_value;
                    r_next.e_cap[slot] = cand.group_capacity;
                    r_next.e_mem[slot] = 8'h00;
                end
            end
            S_DONE: begin
                r_next.st = S_IDLE;
                r_next.status_event = 1'b1;
                r_next.done_flag = 1'b1;
            end
            default: r_next.st = S_IDLE;
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.st <= S_IDLE;
            r_reg.group_limit <= LIMIT_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign mem_req = r_reg.mem;
    assign status_event = r_reg.status_event;
    assign reject_event = r_reg.reject_event;
    assign cfg_out = r_reg.cfg;
endmodule : lapo_open_point
`default_nettype wire

// ---- sim/lapo_mem_model.sv ----
// Behavioural system memory: answers 16-bit word reads, alternately prompt and slow.
// Assumes the bench loads words[] before each command is started.
`timescale 1ns/1ps
`default_nettype none
module lapo_mem_model
    import lapo_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Word read port
    input wire lapo_mem_req_t mem_req,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [15:0] words [0:127];
    logic [1:0] wait_cnt;
    logic slow;
    // ==========
    // Idle data toggles: a stale word never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mem_ack, mem_rdata, wait_cnt, slow} <= '0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req.req && !mem_ack) begin
                if (wait_cnt == 2'h0) begin
                    mem_ack <= 1'b1;
                    // Nonzero address bits 23:8 read ffff
                    mem_rdata <= (mem_req.addr[23:8] == 16'h0) ? words[mem_req.addr[7:1]] : 16'hffff;
                    wait_cnt <= slow ? 2'h3 : 2'h0;
                    slow <= ~slow;
                end else begin
                    wait_cnt <= wait_cnt - 2'h1;
                end
            end
        end
    end
endmodule : lapo_mem_model
`default_nettype wire

// ---- sim/lapo_open_point_sva.sv ----
// Checker on the open command block ports.
// Bound to every lapo_open_point instance.
`timescale 1ns/1ps
`default_nettype none
module lapo_open_point_sva
    import lapo_pkg::*;
(
    // Clock, reset and APB
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Memory port, events and settings
    input wire lapo_mem_req_t mem_req,
    input wire logic mem_ack, status_event, reject_event,
    input wire logic [15:0] mem_rdata,
    input wire lapo_cfg_t cfg_out
);
    // ==========
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy; pready |-> $past(psel) && $past(penable) ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready not a one-cycle access answer");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_evt; status_event |-> !reject_event ##1 !status_event; endproperty
    a_evt: assert property (p_evt) else $error("status event malformed");
    property p_rej; reject_event |=> !reject_event && !status_event; endproperty
    a_rej: assert property (p_rej) else $error("reject event malformed");
    property p_hold; mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr); endproperty
    a_hold: assert property (p_hold) else $error("word request dropped early");
    property p_drop; mem_req.req && mem_ack |=> !mem_req.req; endproperty
    a_drop: assert property (p_drop) else $error("word request held after answer");
    property p_even; mem_req.req |-> !mem_req.addr[0]; endproperty
    a_even: assert property (p_even) else $error("odd word address");
    property p_lim; cfg_out.priority_level <= PRIO_MAX && cfg_out.transmit_window_limit <= WIN_MAX
        && cfg_out.receive_window_limit <= WIN_MAX; endproperty
    a_lim: assert property (p_lim) else $error("stored setting above limit");
    property p_grp2; cfg_out.response_timer_setting != 8'h00 |-> cfg_out.response_timer_group2
        == (cfg_out.response_timer_setting > TIMER_GROUP1_MAX); endproperty
    a_grp2: assert property (p_grp2) else $error("timer period group wrong");
endmodule : lapo_open_point_sva
bind lapo_open_point lapo_open_point_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .mem_req(mem_req), .mem_ack(mem_ack),
    .status_event(status_event), .reject_event(reject_event), .mem_rdata(mem_rdata),
    .cfg_out(cfg_out));
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench: APB command sequences against the open command block.
// Assumes the memory model answers every word request of the block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lapo_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se, mem_ack, status_event, reject_event;
    logic [15:0] mem_rdata;
    lapo_mem_req_t mem_req;
    lapo_cfg_t cfg_out;
    int fails = 0, tests_run = 0;
    // ==========
    initial forever #50 pclk = ~pclk;
    lapo_open_point #(.AP_CAP(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .status_event(status_event), .reject_event(reject_event),
        .cfg_out(cfg_out));
    lapo_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        se = pslverr;
        if (n >= 50) fails++;
        {psel, penable} <= 2'b00;
    endtask : apb
    // Host keeps list contiguous, values legal unless refused
    task automatic op(input logic [2:0] ctl, input logic [7:0] v, o, txw, cap, grp,
        input logic [15:0] st);
        int n = 0;
        mem.words[34] = {(grp != 8'h00) ? 8'h07 : 8'h00, 8'h00};
        mem.words[35] = {8'h00, txw};
        mem.words[37] = {8'h00, cap};
        mem.words[39] = {v, o};
        mem.words[41] = {15'h0, grp != 8'h00};
        mem.words[64] = {grp, 8'h00};
        apb(1'b1, OFF_CMD_A, 32'h0000ab00);
        apb(1'b1, OFF_CMD_B, 32'h00000040);
        apb(1'b1, OFF_CTRL, {29'h0, ctl & 3'h6});
        apb(1'b1, OFF_CTRL, {29'h0, ctl});
        do begin apb(1'b0, OFF_FLAGS, 32'h0); n++; end while (rd[2:1] == 2'b00 && n < 200);
        if (ctl != 3'h7) begin
            chk(rd[2:0], 3'b100);
        end else begin
            chk(rd[2:0], 3'b010);
            apb(1'b0, OFF_STAT_CMD, 32'h0);
            chk(rd, {16'h0, CMD_CODE});
            apb(1'b0, OFF_STAT_A, 32'h0);
            chk(rd, {16'h0, st});
            apb(1'b0, OFF_STAT_B, 32'h0);
            if (st == ST_OK) chk(rd, {16'h0, v, 8'h00});
            apb(1'b0, OFF_STAT_C, 32'h0);
            if (st == ST_NO_GROUP || st == ST_GROUP_FULL) chk(rd, {24'h0, grp});
        end
        apb(1'b1, OFF_FLAGS, 32'h6);
    endtask : op
    initial begin
        {mem.words[36], mem.words[38], mem.words[42]} = '0;
        {mem.words[40], mem.words[43]} = {16'h0200, 16'h0080};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h0);
        chk(32'(se), 32'h1);
        apb(1'b0, OFF_LIMIT, 32'h0);
        chk(rd, {24'h0, LIMIT_RESET});
        op(3'h1, 8'h04, 8'h20, 8'h00, 8'h00, 8'h00, ST_OK);
        op(3'h7, 8'h04, 8'h36, 8'h00, 8'h00, 8'h00, ST_OK);
        chk({cfg_out.response_timer_setting, cfg_out.receive_ack_timer_setting,
            cfg_out.inactivity_timer_setting, cfg_out.transmit_window_limit},
            {DEF_T1, DEF_T2, DEF_TI, DEF_TX_WIN});
        chk({cfg_out.receive_window_limit, cfg_out.window_increment_step,
            cfg_out.retransmit_limit_value, 5'h0, cfg_out.priority_level},
            {DEF_RX_WIN, DEF_STEP, DEF_RETRY, 5'h0, PRIO_MAX});
        chk({cfg_out.max_field_length, 15'h0, cfg_out.host_answers_identification},
            {DEF_FIELD, 16'h0001});
        op(3'h7, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, ST_OPTIONS);
        op(3'h7, 8'h06, 8'h80, 8'h00, 8'h00, 8'h00, ST_OPTIONS);
        op(3'h7, 8'h06, 8'h27, 8'h00, 8'h00, 8'h00, ST_PRIORITY);
        op(3'h7, 8'h06, 8'h20, 8'h80, 8'h00, 8'h00, ST_PARAM_MAX);
        op(3'h7, 8'h05, 8'h20, 8'h00, 8'h00, 8'h00, ST_BAD_VALUE);
        op(3'h7, 8'h04, 8'h20, 8'h00, 8'h00, 8'h00, ST_BAD_VALUE);
        apb(1'b1, OFF_LIMIT, 32'h1);
        op(3'h7, 8'h1c, 8'h40, 8'h00, 8'h02, 8'h00, ST_PARAM_MAX);
        op(3'h7, 8'h10, 8'h40, 8'h00, 8'h01, 8'h00, ST_OK);
        op(3'h7, 8'h12, 8'ha0, 8'h00, 8'h00, 8'h10, ST_OK);
        op(3'h7, 8'h16, 8'ha0, 8'h00, 8'h00, 8'h10, ST_GROUP_FULL);
        op(3'h7, 8'h18, 8'ha0, 8'h00, 8'h00, 8'h20, ST_NO_GROUP);
        op(3'h7, 8'h14, 8'h20, 8'h00, 8'h00, 8'h00, ST_OK);
        op(3'h7, 8'h1a, 8'h20, 8'h00, 8'h00, 8'h00, ST_NO_ROOM);
        complete_run();
    end
    initial begin
        #2000000;
        fails++;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
